// File: bctw_core.sv
// Trip threshold registers, current monitor and serial register port
module bctw_core
   import bctw_pkg::*;
(
   // Core clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Converter link
   input  wire logic       adc_clk,
   input  wire logic [9:0] adc_data,
   input  wire logic       adc_valid,
   // Serial register port
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // Pins and analog status
   input  wire logic       range_pin_hi,
   input  wire logic       range_pin_lo,
   input  wire logic       power_good_out,
   input  wire logic       trip_shutdown,
   // Open-drain indications
   output logic            alert_o,
   output logic            alert_oe,
   output logic            fault_o,
   output logic            fault_oe,
   // To the analog trip comparators
   output logic [1:0]      ratio_sel,
   output logic [1:0]      range_sel,
   output logic [7:0]      fast_code,
   output logic [7:0]      ratio_pct
);

   // ==========================================================================
   // Functions
   function automatic logic [7:0] ratio_to_pct(input logic [1:0] r);
      unique case (r)
         RATIO_125: ratio_to_pct = PCT_125;
         RATIO_150: ratio_to_pct = PCT_150;
         RATIO_175: ratio_to_pct = PCT_175;
         RATIO_200: ratio_to_pct = PCT_200;
      endcase
   endfunction

   function automatic logic [1:0] pin_to_range(input logic hi, input logic lo);
      if (lo)
         pin_to_range = RANGE_25MV;
      else if (hi)
         pin_to_range = RANGE_50MV;
      else
         pin_to_range = RANGE_100MV;
   endfunction

   function automatic logic [7:0] clamp_code(input logic [7:0] c);
      clamp_code = (c < FLOOR_CODE) ? FLOOR_CODE : c;
   endfunction

   // ==========================================================================
   // Crossings
   bctw_smp_if smp ();

   bctw_adc_cap u_cap (
      .adc_clk   (adc_clk),
      .rst       (rst),
      .adc_data  (adc_data),
      .adc_valid (adc_valid),
      .smp       (smp.src)
   );

   logic [6:0] pin_s;
   logic       scl_s, sda_s, pg_s, trip_s, rhi_s, rlo_s, tog_s;

   bctw_sync2 #(.W(7)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({scl_i, sda_i, power_good_out, trip_shutdown, range_pin_hi, range_pin_lo,
             smp.tog}),
      .q   (pin_s)
   );

   assign {scl_s, sda_s, pg_s, trip_s, rhi_s, rlo_s, tog_s} = pin_s;

   // ==========================================================================
   // State
   bctw_i2c_st_t st_q, st_d;
   logic [2:0]   bit_q, bit_d;
   logic [7:0]   sh_q, sh_d, ptr_q, ptr_d;
   logic         pset_q, pset_d, rw_q, rw_d, ackph_q, ackph_d, nack_q, nack_d;
   logic         scl_p_q, sda_p_q, tog_p_q;
   logic         sda_oe_q, sda_oe_d;
   logic [7:0]   code_q, code_d, warn_hi_q, warn_hi_d;
   logic [1:0]   warn_lo_q, warn_lo_d;
   logic [3:0]   ratio_q, ratio_d, range_q, range_d;
   logic [9:0]   cur_q, cur_d;
   logic [1:0]   strap_cnt_q, strap_cnt_d;
   logic         strap_done_q, strap_done_d;
   logic         alert_q, alert_d, fault_q, fault_d;
   logic [1:0]   ratio_sel_q, range_sel_q;
   logic [7:0]   fast_code_q, ratio_pct_q;

   logic         i2c_start, i2c_stop, scl_rise, scl_fall, smp_new, wr_en;
   logic [7:0]   byte_in, rd_now;

   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;
   assign i2c_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign i2c_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign byte_in   = {sh_q[6:0], sda_s};
   assign smp_new   = tog_s ^ tog_p_q;

   // ==========================================================================
   // Register read map
   always_comb begin
      unique case (ptr_q)
         OFS_CUR_HI:  rd_now = cur_q[9:2];
         OFS_CUR_LO:  rd_now = {6'h00, cur_q[1:0]};
         OFS_WARN_HI: rd_now = warn_hi_q;
         OFS_WARN_LO: rd_now = {6'h00, warn_lo_q};
         OFS_CODE:    rd_now = code_q;
         OFS_RATIO:   rd_now = {4'h0, ratio_q};
         OFS_RANGE:   rd_now = {4'h0, range_q};
         default:     rd_now = 8'h00;
      endcase
   end

   // ==========================================================================
   // Serial slave and register file next state
   always_comb begin
      st_d     = st_q;
      bit_d    = bit_q;
      sh_d     = sh_q;
      ptr_d    = ptr_q;
      pset_d   = pset_q;
      rw_d     = rw_q;
      ackph_d  = ackph_q;
      nack_d   = nack_q;
      sda_oe_d = sda_oe_q;
      wr_en    = 1'b0;
      if (i2c_start) begin
         st_d     = ST_ADDR;
         bit_d    = 3'h0;
         pset_d   = 1'b0;
         ackph_d  = 1'b0;
         sda_oe_d = 1'b0;
      end else if (i2c_stop) begin
         st_d     = ST_IDLE;
         ackph_d  = 1'b0;
         sda_oe_d = 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
            end
            ST_ADDR: if (scl_rise) begin
               sh_d  = byte_in;
               bit_d = bit_q + 3'h1;
               if (bit_q == BIT_LAST) begin
                  rw_d = byte_in[0];
                  st_d = (byte_in[7:1] == DEV_ADDR) ? ST_AACK : ST_IDLE;
               end
            end
            ST_AACK, ST_WACK: if (scl_fall) begin
               if (!ackph_q) begin
                  sda_oe_d = 1'b1;
                  ackph_d  = 1'b1;
               end else begin
                  ackph_d = 1'b0;
                  bit_d   = 3'h0;
                  if (st_q == ST_AACK && rw_q) begin
                     sh_d     = rd_now;
                     sda_oe_d = ~rd_now[7];
                     st_d     = ST_RD;
                  end else begin
                     sda_oe_d = 1'b0;
                     st_d     = ST_WR;
                  end
               end
            end
            ST_WR: if (scl_rise) begin
               sh_d  = byte_in;
               bit_d = bit_q + 3'h1;
               if (bit_q == BIT_LAST) begin
                  st_d = ST_WACK;
                  if (!pset_q) begin
                     ptr_d  = byte_in;
                     pset_d = 1'b1;
                  end else begin
                     wr_en = 1'b1;
                     ptr_d = ptr_q + 8'h01;
                  end
               end
            end
            ST_RD: begin
               if (scl_rise) begin
                  bit_d = bit_q + 3'h1;
                  if (bit_q == BIT_LAST)
                     st_d = ST_RACK;
               end else if (scl_fall) begin
                  sda_oe_d = ~sh_q[6];
                  sh_d     = {sh_q[6:0], 1'b0};
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nack_d = sda_s;
                  ptr_d  = ptr_q + 8'h01;
               end else if (scl_fall) begin
                  if (!ackph_q) begin
                     sda_oe_d = 1'b0;
                     ackph_d  = 1'b1;
                  end else begin
                     ackph_d = 1'b0;
                     bit_d   = 3'h0;
                     if (nack_q) begin
                        st_d = ST_IDLE;
                     end else begin
                        sh_d     = rd_now;
                        sda_oe_d = ~rd_now[7];
                        st_d     = ST_RD;
                     end
                  end
               end
            end
         endcase
      end

      code_d       = code_q;
      warn_hi_d    = warn_hi_q;
      warn_lo_d    = warn_lo_q;
      ratio_d      = ratio_q;
      range_d      = range_q;
      strap_cnt_d  = strap_cnt_q;
      strap_done_d = strap_done_q;
      // Pin is read only once the synchroniser has settled after release
      if (!strap_done_q) begin
         strap_cnt_d = strap_cnt_q + 2'h1;
         if (strap_cnt_q == STRAP_WAIT) begin
            range_d      = {2'h0, pin_to_range(rhi_s, rlo_s)};
            strap_done_d = 1'b1;
         end
      end
      // Writes apply at once, even with the channel running
      if (wr_en) begin
         unique case (ptr_q)
            OFS_WARN_HI: warn_hi_d = byte_in;
            OFS_WARN_LO: warn_lo_d = byte_in[1:0];
            OFS_CODE:    code_d    = byte_in;
            OFS_RATIO:   ratio_d   = byte_in[3:0];
            OFS_RANGE:   range_d   = byte_in[3:0];
            default: begin
            end
         endcase
      end

      // Warning only raises the alert; power good and the channel are untouched
      cur_d   = cur_q;
      alert_d = alert_q;
      if (smp_new) begin
         cur_d   = smp.data;
         alert_d = pg_s && (smp.data > {warn_hi_q, warn_lo_q});
      end
      if (!pg_s)
         alert_d = 1'b0;
      fault_d = trip_s;
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q         <= ST_IDLE;
         bit_q        <= 3'h0;
         sh_q         <= 8'h00;
         ptr_q        <= 8'h00;
         pset_q       <= 1'b0;
         rw_q         <= 1'b0;
         ackph_q      <= 1'b0;
         nack_q       <= 1'b0;
         scl_p_q      <= 1'b0;
         sda_p_q      <= 1'b0;
         tog_p_q      <= 1'b0;
         sda_oe_q     <= 1'b0;
         code_q       <= RST_CODE;
         warn_hi_q    <= RST_WARN_HI;
         warn_lo_q    <= RST_WARN_LO;
         ratio_q      <= RST_RATIO;
         range_q      <= RST_RANGE;
         cur_q        <= RST_CUR;
         strap_cnt_q  <= 2'h0;
         strap_done_q <= 1'b0;
         alert_q      <= 1'b0;
         fault_q      <= 1'b0;
         ratio_sel_q  <= RATIO_200;
         range_sel_q  <= RANGE_100MV;
         fast_code_q  <= RST_CODE;
         ratio_pct_q  <= PCT_200;
      end else begin
         st_q         <= st_d;
         bit_q        <= bit_d;
         sh_q         <= sh_d;
         ptr_q        <= ptr_d;
         pset_q       <= pset_d;
         rw_q         <= rw_d;
         ackph_q      <= ackph_d;
         nack_q       <= nack_d;
         scl_p_q      <= scl_s;
         sda_p_q      <= sda_s;
         tog_p_q      <= tog_s;
         sda_oe_q     <= sda_oe_d;
         code_q       <= code_d;
         warn_hi_q    <= warn_hi_d;
         warn_lo_q    <= warn_lo_d;
         ratio_q      <= ratio_d;
         range_q      <= range_d;
         cur_q        <= cur_d;
         strap_cnt_q  <= strap_cnt_d;
         strap_done_q <= strap_done_d;
         alert_q      <= alert_d;
         fault_q      <= fault_d;
         // Comparators see the stored fields one cycle after they change
         ratio_sel_q  <= ratio_q[1:0];
         range_sel_q  <= range_q[1:0];
         fast_code_q  <= clamp_code(code_q);
         ratio_pct_q  <= ratio_to_pct(ratio_q[1:0]);
      end
   end

   // Open-drain pins only ever pull low
   assign sda_o     = 1'b0;
   assign alert_o   = 1'b0;
   assign fault_o   = 1'b0;
   assign sda_oe    = sda_oe_q;
   assign alert_oe  = alert_q;
   assign fault_oe  = fault_q;
   assign ratio_sel = ratio_sel_q;
   assign range_sel = range_sel_q;
   assign fast_code = fast_code_q;
   assign ratio_pct = ratio_pct_q;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_ratio_wr;
      wr_en && ptr_q == OFS_RATIO;
   endsequence

   sequence s_code_wr;
      wr_en && ptr_q == OFS_CODE;
   endsequence

   chk_ratio_decode: assert property (ratio_pct == ratio_to_pct($past(ratio_q[1:0])))
      else $error("ratio percent does not match field");
   chk_ratio_write: assert property (s_ratio_wr |-> ##2 ratio_sel == $past(byte_in[1:0], 2))
      else $error("ratio output missed write");
   chk_range_strap: assert property (!strap_done_q && strap_cnt_q == STRAP_WAIT |=>
      range_q[1:0] == pin_to_range($past(rhi_s), $past(rlo_s)))
      else $error("range not loaded from pin");
   chk_code_write: assert property (s_code_wr |-> ##2
      fast_code == clamp_code($past(byte_in, 2)))
      else $error("code output missed write");
   chk_code_floor: assert property (fast_code >= FLOOR_CODE)
      else $error("fast code below floor");
   chk_fault_follow: assert property (fault_oe == $past(trip_s))
      else $error("fault does not follow trip");
   chk_sample_store: assert property (smp_new |=> cur_q == $past(smp.data))
      else $error("sample not stored");
   chk_alert_gate: assert property (!pg_s |=> !alert_oe)
      else $error("alert without power good");
   chk_alert_set: assert property (smp_new && pg_s && smp.data > {warn_hi_q, warn_lo_q}
      |=> alert_oe)
      else $error("alert missed on high sample");
endmodule

// File: bctw_pkg.sv
// Shared constants and types for the breaker threshold and current warning block
package bctw_pkg;

   // ==========================================================================
   // Serial bus
   // Device address is arbitrary, chosen only for this design
   localparam logic [6:0] DEV_ADDR      = 7'h3a;
   localparam logic [2:0] BIT_LAST      = 3'h7;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0] OFS_CUR_HI    = 8'h00;
   localparam logic [7:0] OFS_CUR_LO    = 8'h01;
   localparam logic [7:0] OFS_WARN_HI   = 8'h22;
   localparam logic [7:0] OFS_WARN_LO   = 8'h23;
   localparam logic [7:0] OFS_CODE      = 8'h2e;
   localparam logic [7:0] OFS_RATIO     = 8'h30;
   localparam logic [7:0] OFS_RANGE     = 8'h33;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] RST_CODE      = 8'hbf;
   localparam logic [3:0] RST_RATIO     = 4'hf;
   localparam logic [3:0] RST_RANGE     = 4'h0;
   localparam logic [7:0] RST_WARN_HI   = 8'hff;
   localparam logic [1:0] RST_WARN_LO   = 2'h3;
   localparam logic [9:0] RST_CUR       = 10'h000;

   // ==========================================================================
   // Field encodings
   localparam logic [1:0] RATIO_125     = 2'h0;
   localparam logic [1:0] RATIO_150     = 2'h1;
   localparam logic [1:0] RATIO_175     = 2'h2;
   localparam logic [1:0] RATIO_200     = 2'h3;
   localparam logic [7:0] PCT_125       = 8'h7d;
   localparam logic [7:0] PCT_150       = 8'h96;
   localparam logic [7:0] PCT_175       = 8'haf;
   localparam logic [7:0] PCT_200       = 8'hc8;
   localparam logic [1:0] RANGE_25MV    = 2'h2;
   localparam logic [1:0] RANGE_50MV    = 2'h1;
   localparam logic [1:0] RANGE_100MV   = 2'h0;
   // 40 percent of full scale code 255, exactly 102 with no rounding
   localparam logic [7:0] FLOOR_CODE    = 8'h66;
   localparam logic [1:0] STRAP_WAIT    = 2'h3;

   // ==========================================================================
   // Serial slave states
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
   } bctw_i2c_st_t;

endpackage

// File: bctw_smp_if.sv
// Sample word and its event toggle, carried from the converter domain
interface bctw_smp_if;
   logic [9:0] data;
   logic       tog;
   modport src (output data, output tog);
   modport dst (input data, input tog);
endinterface

// File: bctw_sync2.sv
// Two-stage synchroniser for levels entering the core clock domain
module bctw_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // ==========================================================================
   // First stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// File: bctw_adc_cap.sv
// Converter-domain capture of each sample, announced by a toggle
module bctw_adc_cap
   import bctw_pkg::*;
(
   // Link clock and reset
   input  wire logic       adc_clk,
   input  wire logic       rst,
   // Converter results
   input  wire logic [9:0] adc_data,
   input  wire logic       adc_valid,
   // Toward the core domain
   bctw_smp_if.src         smp
);
   logic [9:0] data_q, data_d;
   logic       tog_q, tog_d;

   // ==========================================================================
   // Word held still until the next result, so the core may read it late
   always_comb begin
      data_d = data_q;
      tog_d  = tog_q;
      if (adc_valid) begin
         data_d = adc_data;
         tog_d  = ~tog_q;
      end
   end

   always_ff @(posedge adc_clk or posedge rst) begin
      if (rst) begin
         data_q <= RST_CUR;
         tog_q  <= 1'b0;
      end else begin
         data_q <= data_d;
         tog_q  <= tog_d;
      end
   end

   assign smp.data = data_q;
   assign smp.tog  = tog_q;
endmodule

// File: bctw_host_model.sv
// Serial bus master standing in for the host processor
module bctw_host_model
   import bctw_pkg::*;
(
   // Core clock paces the bus
   input  wire logic clk,
   // Bus wire level
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Bus timing
   // Quarter bit of 16 clocks keeps the bus just under 400 kHz
   localparam int Q = 16;

   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   task automatic q();
      repeat (Q) @(posedge clk);
   endtask

   task automatic bit_io(input logic b, output logic r);
      q();
      sda_oe <= ~b;
      q();
      scl <= 1'b1;
      q();
      r = sda;
      q();
      scl <= 1'b0;
   endtask

   task automatic start();
      q();
      sda_oe <= 1'b1;
      q();
      scl <= 1'b0;
   endtask

   task automatic stop();
      q();
      sda_oe <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      sda_oe <= 1'b0;
      q();
   endtask

   task automatic byte_io(input logic [7:0] tx, input logic ack_tx,
                          output logic [7:0] rx, output logic ack_rx);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_tx, ack_rx);
   endtask

   // ==========================================================================
   // Register transfers; ok is high when every byte the host sent was acknowledged
   task automatic wr(input logic [7:0] ofs, input logic [7:0] data, output logic ok);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      start();
      byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
      byte_io(ofs, 1'b1, rx, a1);
      byte_io(data, 1'b1, rx, a2);
      stop();
      ok = !(a0 || a1 || a2);
   endtask

   task automatic rd(input logic [7:0] ofs, output logic [7:0] data, output logic ok);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       nak;
      start();
      byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
      byte_io(ofs, 1'b1, rx, a1);
      stop();
      start();
      byte_io({DEV_ADDR, 1'b1}, 1'b1, rx, a2);
      byte_io(8'hff, 1'b1, data, nak);
      stop();
      ok = !(a0 || a1 || a2);
   endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the trip threshold and current warning core
module tb_top
   import bctw_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Signals
   logic       clk = 1'b0;
   logic       adc_clk = 1'b0;
   logic       rst = 1'b1;
   logic [9:0] adc_data = 10'h000;
   logic       adc_valid = 1'b0;
   logic       range_pin_hi = 1'b0;
   logic       range_pin_lo = 1'b1;
   logic       power_good_out = 1'b0;
   logic       trip_shutdown = 1'b0;
   logic       scl;
   logic       h_oe;
   wire logic  sda;
   logic       sda_o;
   logic       sda_oe;
   logic       alert_o;
   logic       alert_oe;
   logic       fault_o;
   logic       fault_oe;
   logic [1:0] ratio_sel;
   logic [1:0] range_sel;
   logic [7:0] fast_code;
   logic [7:0] ratio_pct;
   int         n_mismatch = 0;
   int         check_count = 0;

   always #20 clk = ~clk;
   always #24 adc_clk = ~adc_clk;
   // Open-drain wire with pull-up
   assign sda = !(h_oe || sda_oe);

   bctw_core dut (.clk(clk), .rst(rst), .adc_clk(adc_clk), .adc_data(adc_data),
      .adc_valid(adc_valid), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .range_pin_hi(range_pin_hi), .range_pin_lo(range_pin_lo),
      .power_good_out(power_good_out), .trip_shutdown(trip_shutdown),
      .alert_o(alert_o), .alert_oe(alert_oe), .fault_o(fault_o), .fault_oe(fault_oe),
      .ratio_sel(ratio_sel), .range_sel(range_sel), .fast_code(fast_code),
      .ratio_pct(ratio_pct));

   bctw_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(h_oe));

   // ==========================================================================
   // Shared tasks
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrr(input logic [7:0] ofs, input logic [7:0] data);
      logic ok;
      host.wr(ofs, data, ok);
      chk("write ack", {9'h000, ok}, 10'h001);
      repeat (4) @(posedge clk);
   endtask

   task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      host.rd(ofs, d, ok);
      chk("read ack", {9'h000, ok}, 10'h001);
      chk($sformatf("reg %h", ofs), {2'h0, d}, {2'h0, exp});
   endtask

   task automatic sample(input logic [9:0] d);
      @(posedge adc_clk);
      adc_data <= d;
      adc_valid <= 1'b1;
      @(posedge adc_clk);
      adc_valid <= 1'b0;
      // Covers the sync and compare latency with margin
      repeat (12) @(posedge clk);
   endtask

   task automatic do_reset(input int n, input logic hi, input logic lo);
      rst <= 1'b1;
      range_pin_hi <= hi;
      range_pin_lo <= lo;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
      repeat (12) @(posedge clk);
   endtask

   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      chk("ratio_sel", {8'h00, ratio_sel}, 10'h003);
      chk("ratio_pct", {2'h0, ratio_pct}, 10'h0c8);
      chk("fast_code", {2'h0, fast_code}, 10'h0bf);
      chk("range_sel", {8'h00, range_sel}, 10'h002);
      chk("drain levels", {7'h00, sda_o, alert_o, fault_o}, 10'h000);
      rdc(OFS_CODE, 8'hbf);
      rdc(OFS_RATIO, 8'h0f);
      rdc(OFS_WARN_HI, 8'hff);
      rdc(OFS_WARN_LO, 8'h03);
      rdc(OFS_CUR_HI, 8'h00);
      rdc(8'h10, 8'h00);
   endtask

   task automatic t_pins();
      logic [1:0] pin [3] = '{2'h1, 2'h2, 2'h0};
      logic [1:0] exp [3] = '{2'h2, 2'h1, 2'h0};
      for (int i = 0; i < 3; i++) begin
         do_reset(4, pin[i][1], pin[i][0]);
         chk("pin range", {8'h00, range_sel}, {8'h00, exp[i]});
      end
   endtask

   task automatic t_ratio();
      logic [7:0] pct [4] = '{8'h7d, 8'h96, 8'haf, 8'hc8};
      power_good_out <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wrr(OFS_RATIO, 8'(i));
         chk("ratio_sel", {8'h00, ratio_sel}, 10'(i));
         chk("ratio_pct", ratio_pct, {2'h0, pct[i]});
      end
   endtask

   task automatic t_range();
      logic [1:0] code [3] = '{2'h2, 2'h1, 2'h0};
      for (int i = 0; i < 3; i++) begin
         wrr(OFS_RANGE, {6'h00, code[i]});
         chk("range_sel", {8'h00, range_sel}, {8'h00, code[i]});
      end
      rdc(OFS_RANGE, 8'h00);
   endtask

   task automatic t_code();
      // Slow trip 10 mV at 200 percent in the 25 mV range
      int c = 10 * 255 * 200 / (25 * 100);
      wrr(OFS_CODE, 8'(c));
      chk("fast_code", {2'h0, fast_code}, 10'(c));
      wrr(OFS_CODE, 8'h65);
      chk("fast_code floor", {2'h0, fast_code}, 10'h066);
      rdc(OFS_CODE, 8'h65);
      wrr(OFS_CODE, 8'hff);
      chk("fast_code top", {2'h0, fast_code}, 10'h0ff);
   endtask

   task automatic t_adc();
      wrr(OFS_WARN_HI, 8'h40);
      wrr(OFS_WARN_LO, 8'h01);
      sample(10'h2c5);
      rdc(OFS_CUR_HI, 8'hb1);
      rdc(OFS_CUR_LO, 8'h01);
      chk("alert over", {9'h000, alert_oe}, 10'h001);
      chk("fault quiet", {9'h000, fault_oe}, 10'h000);
      sample(10'h101);
      chk("alert equal", {9'h000, alert_oe}, 10'h000);
      sample(10'h102);
      chk("alert above", {9'h000, alert_oe}, 10'h001);
      power_good_out <= 1'b0;
      sample(10'h3ff);
      chk("alert no pg", {9'h000, alert_oe}, 10'h000);
   endtask

   task automatic t_fault();
      trip_shutdown <= 1'b1;
      repeat (5) @(posedge clk);
      chk("fault set", {9'h000, fault_oe}, 10'h001);
      trip_shutdown <= 1'b0;
      repeat (5) @(posedge clk);
      chk("fault clear", {9'h000, fault_oe}, 10'h000);
   endtask

   // ==========================================================================
   // Main sequence and hang guard
   initial begin
      do_reset(16, 1'b0, 1'b1);
      t_reset();
      t_ratio();
      t_range();
      t_code();
      t_adc();
      t_fault();
      t_pins();
      final_report();
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule
